// *** rtl/bwei_pkg.sv ***
// Constants shared by the bus word error injector and its helpers.
// Assumes a 250 MHz clock and 1 us bit times on the serial bus.
package bwei_pkg;

  // ==========================================================================
  // Timing
  localparam int BIT_TIME_NS   = 1000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int CYC_PER_BIT   = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int HALF_CYC      = CYC_PER_BIT / 2;
  localparam int CYC_W         = $clog2(CYC_PER_BIT);
  localparam int SKEW_STEP_NS  = 20;
  localparam int SKEW_STEP_CYC = (SKEW_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EARLY_REF_NS  = 250;
  localparam int EARLY_REF_CYC = EARLY_REF_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Word layout
  localparam int SYNC_BITS   = 3;
  localparam int DATA_BITS   = 16;
  localparam int NORMAL_BITS = 20;
  localparam int MIN_FRAME   = 17;
  localparam int MAX_FRAME   = 27;
  localparam int ADDR_MSB    = 15;
  localparam int ADDR_LSB    = 11;

  // ==========================================================================
  // Register offsets
  localparam logic [15:0] ADDR_FRAME_LEN  = 16'h00a4;
  localparam logic [15:0] ADDR_WORD_COUNT = 16'h0146;
  localparam logic [15:0] ADDR_GAP_LEN    = 16'h0152;
  localparam logic [15:0] ADDR_ERR_SELECT = 16'h0160;
  localparam logic [15:0] ADDR_MAN_KIND   = 16'h0162;
  localparam logic [15:0] ADDR_BIT_TIME   = 16'h0164;
  localparam logic [15:0] ADDR_MASK_LOW   = 16'h0166;
  localparam logic [15:0] ADDR_MASK_HIGH  = 16'h0168;
  localparam logic [15:0] ADDR_STATUS     = 16'h016a;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] RST_MAN_KIND  = 16'h8000;
  localparam logic [15:0] RST_BIT_TIME  = 16'h0008;
  localparam logic [15:0] RST_FRAME_LEN = 16'h0013;
  localparam logic [15:0] RST_ZERO      = 16'h0000;

  // ==========================================================================
  // Error select fields
  localparam int SEL_MANCHESTER = 15;
  localparam int SEL_PARITY     = 14;
  localparam int SEL_SYNC       = 13;
  localparam int SEL_BIT_COUNT  = 12;
  localparam int SEL_ADDR_PLUS  = 11;
  localparam int SEL_EXTRA_WC   = 10;
  localparam int SEL_FEWER_WC   = 9;
  localparam int SEL_WRONG_BUS  = 8;
  localparam int SEL_WORD_GAP   = 7;
  localparam int SEL_FIRST_STS  = 3;
  localparam int SEL_SECOND_STS = 2;
  localparam int SEL_FIRST_CMD  = 1;
  localparam int SEL_SECOND_CMD = 0;

  // Manchester error kind fields
  localparam int KIND_FORCE_HIGH = 15;
  localparam int KIND_FORCE_LOW  = 14;
  localparam int KIND_SYNC_HALF  = 13;
  localparam int KIND_LAST_HALF  = 12;
  localparam int KIND_LATE       = 11;
  localparam int KIND_EARLY      = 10;
  localparam int KIND_SKEW_LSB   = 0;
  localparam int KIND_SKEW_W     = 4;

  // Word kinds on the input stream
  typedef enum logic [1:0] {
    WORD_COMMAND = 2'b00,
    WORD_STATUS  = 2'b01,
    WORD_DATA    = 2'b10
  } word_kind_e;

  // Transmit sequencer states, Gray along idle, gap, send
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_GAP  = 2'b01,
    TX_SEND = 2'b11
  } tx_state_e;

endpackage : bwei_pkg

// *** rtl/word_fifo.sv ***
// Word FIFO between the message sequencer and the word encoder.
// Assumes one clock; both sides use valid and ready.
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             wrValid,
  output logic                  wrReady,
  input  wire logic [WIDTH-1:0] wrData,
  output logic                  rdValid,
  input  wire logic             rdReady,
  output logic [WIDTH-1:0]      rdData
);
  localparam int AW = $clog2(DEPTH);

  // ==========================================================================
  // Elaboration check
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("word_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_q;
  logic [AW:0]      rdPtr_q;
  logic             full;
  logic             empty;

  // Extra pointer bit tells full from empty
  assign full    = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign empty   = (wrPtr_q == rdPtr_q);
  assign wrReady = ~full;
  assign rdValid = ~empty;
  assign rdData  = mem[rdPtr_q[AW-1:0]];

  // ==========================================================================
  // Pointers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else if (ce) begin
      if (wrValid && !full) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (rdReady && !empty) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
    end
  end

  // Storage needs no reset; empty hides stale entries
  always_ff @(posedge clk) begin
    if (ce && wrValid && !full) begin
      mem[wrPtr_q[AW-1:0]] <= wrData;
    end
  end

endmodule : word_fifo

// *** rtl/bit_timer.sv ***
// Bit time counter: cycle within the bit and bit index within a run.
// Assumes start is a one-cycle pulse; a start on the last cycle chains runs.
`timescale 1ns/10ps
module bit_timer
  import bwei_pkg::*;
#(
  parameter int CYC   = CYC_PER_BIT,
  parameter int LEN_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             start,
  input  wire logic [LEN_W-1:0] lenBits,
  output logic [CYC_W-1:0]      cycle,
  output logic [LEN_W-1:0]      bitIdx,
  output logic                  running,
  output logic                  done
);
  // ==========================================================================
  // Elaboration check
  if (CYC < 4 || CYC > (1 << CYC_W)) begin : g_bad
    $error("bit_timer cycle count does not fit its counter");
  end

  logic [LEN_W-1:0] len_q;
  logic             lastCycle;

  assign lastCycle = running && (cycle == CYC_W'(CYC - 1));
  assign done      = lastCycle && (bitIdx == len_q - 1'b1);

  // ==========================================================================
  // Counters
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cycle   <= '0;
      bitIdx  <= '0;
      len_q   <= '0;
      running <= 1'b0;
    end else if (ce) begin
      if (start) begin
        cycle   <= '0;
        bitIdx  <= '0;
        len_q   <= lenBits;
        running <= (lenBits != '0);
      end else if (lastCycle) begin
        cycle <= '0;
        if (done) begin
          running <= 1'b0;
        end else begin
          bitIdx <= bitIdx + 1'b1;
        end
      end else if (running) begin
        cycle <= cycle + 1'b1;
      end
    end
  end

endmodule : bit_timer

// *** rtl/bus_word_error_injector.sv ***
// Word encoder with error injection for a dual redundant serial data bus.
// Assumes an upstream sequencer feeding words with their kind, data index
// and bus; registers are written through a plain address/data port.
//
// How it works
// - Reset: forced-high error at bit eight.
// - Kind bit 15 holds bit high.
// - Kind bit 14 holds bit low.
// - Kind bit 13 forces one half-bit; 12 picks.
// - Kind bit 11 delays crossing by steps.
// - Kind bit 10 advances crossing from 250 ns.
// - Parity select inverts parity bit.
// - Sync select inverts sync pattern.
// - Bit count select uses frame length.
// - Frame length ignored unless bit count selected.
// - Word count error overrides command count in terminal mode.
// - Wrong bus response unless switchover enabled.
// - Gap select delays affected data word.
// - Two masks choose affected data words.
// - Low select bits choose command and status words.
// - Select word bit positions as laid out.
// - Address error adds one to status address in terminal mode.
`timescale 1ns/10ps
module bus_word_error_injector
  import bwei_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Register port
  input  wire logic [15:0] regAddr,
  input  wire logic        regWrEn,
  input  wire logic [15:0] regWrData,
  input  wire logic        regRdEn,
  output logic      [15:0] regRdData,
  // Message context
  input  wire logic        multiTerminalMode,
  input  wire logic        switchoverEnabled,
  input  wire logic [4:0]  cmdWordCount,
  output logic      [5:0]  txWordCount,
  // Word stream in
  input  wire logic        inValid,
  output logic             inReady,
  input  wire logic [15:0] inWord,
  input  wire logic [1:0]  inKind,
  input  wire logic        inSecond,
  input  wire logic [4:0]  inIndex,
  input  wire logic        inBusB,
  // Serial side
  output logic             txLevel,
  output logic             txEnable,
  output logic             txBusB,
  output logic             txBusy
);
  localparam int FW = 25;

  // ==========================================================================
  // Elaboration check
  if (FIFO_DEPTH < 2) begin : g_bad
    $error("FIFO_DEPTH must be at least 2");
  end

  // ==========================================================================
  // Registers
  logic [15:0] frameLen_q;
  logic [15:0] wordCount_q;
  logic [15:0] gapLen_q;
  logic [15:0] errSelect_q;
  logic [15:0] manKind_q;
  logic [15:0] bitTime_q;
  logic [15:0] maskLow_q;
  logic [15:0] maskHigh_q;
  logic        fifoValid;
  tx_state_e   state_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frameLen_q  <= RST_FRAME_LEN;
      wordCount_q <= RST_ZERO;
      gapLen_q    <= RST_ZERO;
      errSelect_q <= RST_ZERO;
      manKind_q   <= RST_MAN_KIND;
      bitTime_q   <= RST_BIT_TIME;
      maskLow_q   <= RST_ZERO;
      maskHigh_q  <= RST_ZERO;
    end else if (ce && regWrEn) begin
      if (regAddr == ADDR_FRAME_LEN) begin
        frameLen_q <= regWrData;
      end else if (regAddr == ADDR_WORD_COUNT) begin
        wordCount_q <= regWrData;
      end else if (regAddr == ADDR_GAP_LEN) begin
        gapLen_q <= regWrData;
      end else if (regAddr == ADDR_ERR_SELECT) begin
        errSelect_q <= regWrData;
      end else if (regAddr == ADDR_MAN_KIND) begin
        manKind_q <= regWrData;
      end else if (regAddr == ADDR_BIT_TIME) begin
        bitTime_q <= regWrData;
      end else if (regAddr == ADDR_MASK_LOW) begin
        maskLow_q <= regWrData;
      end else if (regAddr == ADDR_MASK_HIGH) begin
        maskHigh_q <= regWrData;
      end
    end
  end

  // Read data is registered; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= 16'h0000;
    end else if (ce && regRdEn) begin
      if (regAddr == ADDR_FRAME_LEN) begin
        regRdData <= frameLen_q;
      end else if (regAddr == ADDR_WORD_COUNT) begin
        regRdData <= wordCount_q;
      end else if (regAddr == ADDR_GAP_LEN) begin
        regRdData <= gapLen_q;
      end else if (regAddr == ADDR_ERR_SELECT) begin
        regRdData <= errSelect_q;
      end else if (regAddr == ADDR_MAN_KIND) begin
        regRdData <= manKind_q;
      end else if (regAddr == ADDR_BIT_TIME) begin
        regRdData <= bitTime_q;
      end else if (regAddr == ADDR_MASK_LOW) begin
        regRdData <= maskLow_q;
      end else if (regAddr == ADDR_MASK_HIGH) begin
        regRdData <= maskHigh_q;
      end else if (regAddr == ADDR_STATUS) begin
        regRdData <= {12'h000, ~inReady, fifoValid, state_q};
      end else begin
        regRdData <= 16'h0000;
      end
    end
  end

  // ==========================================================================
  // Word FIFO
  logic          fifoPop;
  logic [FW-1:0] fifoData;
  logic [15:0]   nxWord;
  logic [1:0]    nxKind;
  logic          nxSecond;
  logic [4:0]    nxIndex;
  logic          nxBusB;

  word_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .wrValid (inValid),
    .wrReady (inReady),
    .wrData  ({inWord, inKind, inSecond, inIndex, inBusB}),
    .rdValid (fifoValid),
    .rdReady (fifoPop),
    .rdData  (fifoData)
  );

  assign {nxWord, nxKind, nxSecond, nxIndex, nxBusB} = fifoData;

  // ==========================================================================
  // Which words carry the errors
  logic        nxAffected;
  logic [31:0] wordMask;
  logic        nxGap;
  logic [15:0] nxFrameBits;
  logic [15:0] frameClamped;

  assign wordMask = {maskHigh_q, maskLow_q};

  // Command and status word choice; data word masks
  always_comb begin
    nxAffected = 1'b0;
    if (nxKind == WORD_COMMAND) begin
      nxAffected = nxSecond ? errSelect_q[SEL_SECOND_CMD] : errSelect_q[SEL_FIRST_CMD];
    end else if (nxKind == WORD_STATUS) begin
      nxAffected = nxSecond ? errSelect_q[SEL_SECOND_STS] : errSelect_q[SEL_FIRST_STS];
    end else if (nxKind == WORD_DATA) begin
      nxAffected = wordMask[nxIndex];
    end
  end

  // Out-of-range lengths are held to the legal span
  always_comb begin
    frameClamped = frameLen_q;
    if (frameLen_q < 16'(MIN_FRAME)) begin
      frameClamped = 16'(MIN_FRAME);
    end else if (frameLen_q > 16'(MAX_FRAME)) begin
      frameClamped = 16'(MAX_FRAME);
    end
  end

  // Word length only follows the register under bit count
  assign nxFrameBits = (nxAffected && errSelect_q[SEL_BIT_COUNT]) ? frameClamped
                                                                  : 16'(NORMAL_BITS);
  // Gap only before affected data words
  assign nxGap = nxAffected && errSelect_q[SEL_WORD_GAP] && (nxKind == WORD_DATA)
                 && (gapLen_q != 16'h0000);

  // ==========================================================================
  // Sequencer
  logic             launch;
  logic             timerStart;
  logic [15:0]      timerLen;
  logic [CYC_W-1:0] cyc;
  logic [15:0]      bitIdx;
  logic             timerDone;
  logic [15:0]      frameBits_q;

  // A word follows the previous one with no idle cycle
  assign launch     = fifoValid && ((state_q == TX_IDLE) || (state_q == TX_SEND && timerDone));
  assign fifoPop    = launch;
  assign timerStart = launch || (state_q == TX_GAP && timerDone);
  assign timerLen   = launch ? (nxGap ? gapLen_q : nxFrameBits) : frameBits_q;

  bit_timer #(
    .CYC   (CYC_PER_BIT),
    .LEN_W (16)
  ) u_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .start   (timerStart),
    .lenBits (timerLen),
    .cycle   (cyc),
    .bitIdx  (bitIdx),
    .running (),
    .done    (timerDone)
  );

  // State follows the timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= TX_IDLE;
    end else if (ce) begin
      case (state_q)
        TX_IDLE: begin
          if (launch) begin
            state_q <= nxGap ? TX_GAP : TX_SEND;
          end
        end
        TX_GAP: begin
          if (timerDone) begin
            state_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (launch) begin
            state_q <= nxGap ? TX_GAP : TX_SEND;
          end else if (timerDone) begin
            state_q <= TX_IDLE;
          end
        end
        default: begin
          state_q <= TX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Current word
  logic [15:0] curWord_q;
  logic        curParity_q;
  logic        curPosSync_q;
  logic        curSyncInv_q;
  logic        curManch_q;
  logic        curBusB_q;
  logic [15:0] sentWord;

  // Status address plus one in terminal mode
  always_comb begin
    sentWord = nxWord;
    if (nxKind == WORD_STATUS && nxAffected && multiTerminalMode
        && errSelect_q[SEL_ADDR_PLUS]) begin
      sentWord[ADDR_MSB:ADDR_LSB] = nxWord[ADDR_MSB:ADDR_LSB] + 5'h01;
    end
  end

  // Latched at launch so writes mid-word, except to kind and bit time, cannot tear it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      curWord_q    <= 16'h0000;
      curParity_q  <= 1'b0;
      curPosSync_q <= 1'b0;
      curSyncInv_q <= 1'b0;
      curManch_q   <= 1'b0;
      curBusB_q    <= 1'b0;
      frameBits_q  <= 16'(NORMAL_BITS);
    end else if (ce && launch) begin
      curWord_q    <= sentWord;
      curParity_q  <= (~^sentWord) ^ (nxAffected && errSelect_q[SEL_PARITY]);
      curPosSync_q <= (nxKind != WORD_DATA);
      curSyncInv_q <= nxAffected && errSelect_q[SEL_SYNC];
      curManch_q   <= nxAffected && errSelect_q[SEL_MANCHESTER];
      // Answer on the other bus unless switchover is enabled
      curBusB_q    <= nxBusB ^ ((nxKind != WORD_COMMAND) && errSelect_q[SEL_WRONG_BUS]
                                && !switchoverEnabled);
      frameBits_q  <= nxFrameBits;
    end
  end

  // ==========================================================================
  // Line level
  logic [3:0]  skewSteps;
  logic [8:0]  crossAt;
  logic        errBit;
  logic        secondHalf;
  logic        nominal;
  logic        level;
  logic [15:0] dataPos;
  logic [2:0]  halfIdx;

  assign skewSteps  = manKind_q[KIND_SKEW_LSB +: KIND_SKEW_W];
  // Only the programmed bit time is disturbed
  assign errBit     = curManch_q && (bitIdx == bitTime_q);
  assign secondHalf = (cyc >= CYC_W'(HALF_CYC));
  assign dataPos    = bitIdx - 16'(SYNC_BITS);
  assign halfIdx    = {bitIdx[1:0], secondHalf};

  // Crossing point of the selected bit moves late or early
  always_comb begin
    crossAt = 9'(HALF_CYC);
    if (errBit && manKind_q[KIND_LATE]) begin
      // Late by one step per count, plus one
      crossAt = 9'(HALF_CYC + (int'(skewSteps) + 1) * SKEW_STEP_CYC);
    end else if (errBit && manKind_q[KIND_EARLY]) begin
      // Early from the reference, counts pull it back
      crossAt = 9'(HALF_CYC - EARLY_REF_CYC + (int'(skewSteps) + 1) * SKEW_STEP_CYC);
    end
  end

  // Undisturbed sync, Manchester bits, parity and padding
  always_comb begin
    nominal = 1'b0;
    if (bitIdx < 16'(SYNC_BITS)) begin
      nominal = curPosSync_q ? (halfIdx < 3'd3) : (halfIdx >= 3'd3);
      nominal = nominal ^ curSyncInv_q;
    end else begin
      if (dataPos < 16'(DATA_BITS)) begin
        nominal = curWord_q[4'(DATA_BITS - 1) - dataPos[3:0]];
      end else if (dataPos == 16'(DATA_BITS)) begin
        nominal = curParity_q;
      end
      // Padding bits past parity are coded as zeros
      if ({1'b0, cyc} >= crossAt) begin
        nominal = ~nominal;
      end
    end
  end

  // Forced levels override the coded level
  always_comb begin
    level = nominal;
    if (errBit && manKind_q[KIND_SYNC_HALF]) begin
      // Only the chosen half of the bit is forced
      if (secondHalf == manKind_q[KIND_LAST_HALF]) begin
        level = manKind_q[KIND_FORCE_HIGH];
      end
    end else if (errBit && manKind_q[KIND_FORCE_HIGH]) begin
      level = 1'b1;
    end else if (errBit && manKind_q[KIND_FORCE_LOW]) begin
      level = 1'b0;
    end
  end

  // ==========================================================================
  // Outputs from flops; one cycle behind the timer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txLevel  <= 1'b0;
      txEnable <= 1'b0;
      txBusB   <= 1'b0;
      txBusy   <= 1'b0;
    end else if (ce) begin
      txLevel  <= (state_q == TX_SEND) && level;
      txEnable <= (state_q == TX_SEND);
      txBusB   <= curBusB_q;
      txBusy   <= (state_q != TX_IDLE) || fifoValid;
    end
  end

  // Word count taken from the error register when selected in terminal mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txWordCount <= 6'h20;
    end else if (ce) begin
      if (multiTerminalMode && (errSelect_q[SEL_EXTRA_WC] || errSelect_q[SEL_FEWER_WC])) begin
        txWordCount <= (wordCount_q[4:0] == 5'h00) ? 6'h20 : {1'b0, wordCount_q[4:0]};
      end else begin
        txWordCount <= (cmdWordCount == 5'h00) ? 6'h20 : {1'b0, cmdWordCount};
      end
    end
  end

endmodule : bus_word_error_injector

// *** tb/bwei_chk.sv ***
// Port assertions for the word error injector.
// Assumes a bind from tb and one clock domain.
`timescale 1ns/10ps
module bwei_chk
  import bwei_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic [15:0] regAddr,
  input wire logic        regWrEn,
  input wire logic [15:0] regWrData,
  input wire logic        regRdEn,
  input wire logic [15:0] regRdData,
  input wire logic        inValid,
  input wire logic        inReady,
  input wire logic [1:0]  inKind,
  input wire logic        txLevel,
  input wire logic        txEnable,
  input wire logic        txBusy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] onCnt_q;
  // Length of each burst on the line
  always_ff @(posedge clk) begin
    if (!rst_n || !txEnable) onCnt_q <= 16'h0000;
    else onCnt_q <= onCnt_q + 16'h0001;
  end
  // ==========================================================================
  // Assertions
  a_idle_level_low: assert property (!txEnable |-> !txLevel)
    else $error("line level high while idle");
  a_full_is_busy: assert property (!inReady |-> txBusy)
    else $error("refusing words while idle");
  a_take_sets_busy: assert property (inValid && inReady && ce |-> ##2 txBusy)
    else $error("busy missing after take");
  a_word_min_len: assert property ($fell(txEnable) |-> onCnt_q >= 16'd4250)
    else $error("word shorter than 17 bits");
  a_sync_half_stable: assert property ($rose(txEnable) |=> $stable(txLevel)[*8])
    else $error("first sync half not steady");
  a_start_latency: assert property (inValid && inReady && ce && !txBusy
    && inKind != WORD_DATA |-> ##[2:3] txEnable)
    else $error("word did not start in time");
  a_unmapped_zero: assert property (regRdEn && ce && regAddr == 16'h0002
    |=> regRdData == 16'h0000)
    else $error("unmapped read not zero");
  a_read_holds: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data moved");
  a_gap_readback: assert property (regWrEn && regAddr == ADDR_GAP_LEN ##1
    regRdEn && regAddr == ADDR_GAP_LEN |=> regRdData == $past(regWrData, 2))
    else $error("gap length not kept");
endmodule : bwei_chk

// *** tb/word_receiver.sv ***
// Far side receiver: samples the line mid each half bit.
// Assumes 125 cycle half bits and words back to back.
`timescale 1ns/10ps
module word_receiver (
  input wire logic clk,
  input wire logic txEnable,
  input wire logic txLevel
);
  int cnt = 0;
  bit halves[$];
  // Mid-half sampling so early shifts and late shifts under 13 steps do not alias
  always @(posedge clk) begin
    if (txEnable) begin
      if (cnt % 125 == 62) halves.push_back(txLevel);
      cnt <= cnt + 1;
    end else cnt <= 0;
  end
endmodule : word_receiver

// *** tb/tb.sv ***
// Self-checking bench for the word error injector.
// Assumes the checker and receiver compiled first.
`timescale 1ns/10ps
module tb;
  import bwei_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, regWrEn = 0, regRdEn = 0, inValid = 0, mt = 0, so = 1;
  logic inSecond = 0, inBusB = 0, inReady, txLevel, txEnable, txBusB, txBusy;
  logic [15:0] regAddr = 0, regWrData = 0, regRdData, inWord = 0, r;
  logic [1:0] inKind = 0;
  logic [4:0] inIndex = 0;
  logic [5:0] txWordCount;
  int fails = 0, n_checks = 0;
  logic [31:0] rng = 32'd59603;
  bit expQ[$];
  always #2 clk = ~clk;
  bus_word_error_injector bus_word_error_injector_inst (.clk(clk), .rst_n(rst_n),
    .ce(ce), .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(regRdData), .multiTerminalMode(mt),
    .switchoverEnabled(so), .cmdWordCount(5'h01), .txWordCount(txWordCount),
    .inValid(inValid), .inReady(inReady), .inWord(inWord), .inKind(inKind),
    .inSecond(inSecond), .inIndex(inIndex), .inBusB(inBusB), .txLevel(txLevel),
    .txEnable(txEnable), .txBusB(txBusB), .txBusy(txBusy));
  word_receiver word_receiver_inst (.clk(clk), .txEnable(txEnable), .txLevel(txLevel));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Bus tasks end one idle cycle after the strobe falls, so strobes never merge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    regAddr = a; regWrData = d; regWrEn = 1;
    @(negedge clk) regWrEn = 0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    regAddr = a; regRdEn = 1;
    @(negedge clk) regRdEn = 0;
    d = regRdData;
    @(negedge clk);
  endtask : rd
  // Reference halves of one word: sync, data MSB first, odd parity, zeros
  function automatic void build(logic [1:0] k, logic [15:0] w, bit sInv, bit pInv,
                                int len, int ft, int fl);
    bit s, d;
    s = (k != WORD_DATA) ^ sInv;
    expQ = {};
    for (int i = 0; i < len; i++) begin
      d = (i < 3) ? 1'b0 : (i < 19) ? w[18-i] : (i == 19) ? (~^w) ^ pInv : 1'b0;
      if (i < 3) begin
        expQ.push_back((i == ft) ? fl[0] : (2*i < 3) ? s : ~s);
        expQ.push_back((2*i+1 < 3) ? s : ~s);
      end else if (i == ft) begin
        expQ.push_back(fl[1] ? d : fl[0]);
        expQ.push_back(fl[1] ? d : fl[0]);
      end else begin
        expQ.push_back(d);
        expQ.push_back(~d);
      end
    end
  endfunction : build
  task automatic run(input logic [15:0] sel, input logic [1:0] k, input logic [4:0] idx,
                     input bit sec, input int len, input bit sInv, input bit pInv,
                     input int ft, input int fl);
    logic [63:0] got, exp;
    wr(ADDR_ERR_SELECT, sel);
    rng = xs(rng);
    inSecond = sec; inKind = k; inIndex = idx; inWord = rng[15:0]; inValid = 1;
    @(negedge clk) inValid = 0;
    @(negedge clk);
    for (int i = 0; i < 8000 && txBusy !== 1'b0; i++) @(negedge clk);
    check(64'(txBusy), 64'h0);
    build(k, inWord + {sel[11], 11'h000}, sInv, pInv, len, ft, fl);
    got = 0;
    exp = 0;
    foreach (expQ[i]) exp[i] = expQ[i];
    foreach (word_receiver_inst.halves[i]) got[i] = word_receiver_inst.halves[i];
    check(got, exp);
    check(64'(word_receiver_inst.halves.size()), 64'(expQ.size()));
    word_receiver_inst.halves.delete();
    $display("test done sel=%h kind=%h", sel, k);
  endtask : run
  task automatic summarize;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // Watchdog past about 70k cycles of words, still under 100k
  initial begin
    #360000;
    fails++;
    summarize();
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    rd(ADDR_MAN_KIND, r);
    check(r, 16'h8000);
    rd(ADDR_BIT_TIME, r);
    check(r, 16'h0008);
    rd(ADDR_FRAME_LEN, r);
    check(r, 16'h0013);
    rd(16'h0002, r);
    check(r, 16'h0000);
    wr(ADDR_GAP_LEN, 16'h0005);
    rd(ADDR_GAP_LEN, r);
    check(r, 16'h0005);
    check(txWordCount, 6'h01);
    $display("test done registers");
    wr(ADDR_MASK_LOW, 16'h0001);
    run(16'h0000, WORD_COMMAND, 0, 0, 20, 0, 0, -1, 0);
    run(16'h4000, WORD_DATA, 0, 0, 20, 0, 1, -1, 0);
    run(16'h4000, WORD_DATA, 1, 0, 20, 0, 0, -1, 0);
    run(16'h2002, WORD_COMMAND, 0, 0, 20, 1, 0, -1, 0);
    run(16'h2002, WORD_COMMAND, 0, 1, 20, 0, 0, -1, 0);
    run(16'h1002, WORD_COMMAND, 0, 0, 19, 0, 0, -1, 0);
    wr(ADDR_FRAME_LEN, 16'h001b);
    run(16'h0002, WORD_COMMAND, 0, 0, 20, 0, 0, -1, 0);
    run(16'h1002, WORD_COMMAND, 0, 0, 27, 0, 0, -1, 0);
    run(16'h8002, WORD_COMMAND, 0, 0, 20, 0, 0, 8, 1);
    wr(ADDR_MAN_KIND, 16'h4000);
    wr(ADDR_BIT_TIME, 16'(3 + rng[3:0]));
    run(16'h8002, WORD_COMMAND, 0, 0, 20, 0, 0, 3 + rng[3:0], 0);
    wr(ADDR_MAN_KIND, 16'h6000);
    wr(ADDR_BIT_TIME, 16'h0001);
    run(16'h8002, WORD_COMMAND, 0, 0, 20, 0, 0, 1, 0);
    wr(ADDR_MAN_KIND, 16'h080f);
    wr(ADDR_BIT_TIME, 16'h000a);
    run(16'h8002, WORD_COMMAND, 0, 0, 20, 0, 0, 10, 2);
    mt = 1;
    so = 0;
    wr(ADDR_WORD_COUNT, 16'h0005);
    run(16'h0d08, WORD_STATUS, 0, 0, 20, 0, 0, -1, 0);
    check(txBusB, 1'b1);
    check(txWordCount, 6'h05);
    summarize();
  end
endmodule : tb
bind bus_word_error_injector bwei_chk bwei_chk_inst (.*);
